//--- rtl/input_function_decode.v
// One digital input decoded against its function code.
// Assumes the level is already synchronised; the code comes from a register.
`timescale 1ns/1ps
`default_nettype none
`include "servo_map.vh"
module input_function_decode (
  input  wire [11:0] code,
  input  wire        level,
  output reg  [7:0]  on_vec,
  output reg  [7:0]  off_vec
);
  reg [7:0] map;

  always @* begin
    map = 8'h00;
    case (code)
      `FN_SON:  map[`F_SON]  = 1'b1;
      `FN_TRQ:  map[`F_TRQ]  = 1'b1;
      `FN_SPEED_SELECT_LOW: map[`F_SPEED_SELECT_LOW] = 1'b1;
      `FN_SPEED_SELECT_HIGH: map[`F_SPEED_SELECT_HIGH] = 1'b1;
      `FN_ALARM_CLEAR_INPUT: map[`F_ALARM_CLEAR_INPUT] = 1'b1;
      `FN_EMG:  map[`F_EMG]  = 1'b1;
      `FN_NL:   map[`F_NL]   = 1'b1;
      `FN_PL:   map[`F_PL]   = 1'b1;
      default:  map = 8'h00;
    endcase
    on_vec  = map & {8{level}};
    off_vec = map & {8{~level}};
  end
endmodule
`default_nettype wire

//--- rtl/servo_map.vh
// Address map, field positions, reset values and codes of the servo command block.
// Included by the command block and its input decoder; holds definitions only.
`ifndef SERVO_MAP_VH
`define SERVO_MAP_VH

`define OFS_CTRL      7'h00
`define OFS_MODE      7'h04
`define OFS_PRESET1   7'h08
`define OFS_PRESET2   7'h0C
`define OFS_PRESET3   7'h10
`define OFS_JOG       7'h14
`define OFS_FUNC_BASE 7'h18
`define OFS_FUNC_LAST 7'h38
`define OFS_STATUS    7'h3C
`define OFS_SPEED     7'h40

`define CTRL_SON_BIT     0
`define CTRL_RESTART_BIT 1
`define MODE_ACTIVE_LSB  8

`define MODE_SPEED    8'h02
`define MODE_RST      8'h00
`define PRESET_MAX    32'h0000C350
`define PRESET_MIN    32'hFFFF3CB0
`define JOG_RST       16'h0014
`define JOG_MAX       16'h1388
`define JOG_SCALE     32'h0000000A
`define STEP0         16'h0001
`define STEP1         16'h000A
`define STEP2         16'h0064
`define STEP3         16'h03E8
`define DIGIT_LAST    2'h3

`define FN_NONE  12'h000
`define FN_SON   12'h101
`define FN_TRQ   12'h109
`define FN_SPEED_SELECT_LOW  12'h114
`define FN_SPEED_SELECT_HIGH  12'h115
`define FN_ALARM_CLEAR_INPUT  12'h102
`define FN_EMG   12'h021
`define FN_NL    12'h022
`define FN_PL    12'h023

`define F_SON  0
`define F_TRQ  1
`define F_SPEED_SELECT_LOW 2
`define F_SPEED_SELECT_HIGH 3
`define F_ALARM_CLEAR_INPUT 4
`define F_EMG  5
`define F_NL   6
`define F_PL   7

`define ST_FLT_EMG 0
`define ST_FLT_NL  1
`define ST_FLT_PL  2
`define ST_SERVO   3
`define ST_JOG     4
`define ST_SPEED_SELECT_LOW    5
`define ST_SPEED_SELECT_HIGH    6
`define ST_TRQ     7
`define ST_ANALOG  8

`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2

`endif

//--- rtl/servo_speed_select_and_jog.v
// Speed command selection, keypad jog and input-function handling of a servo drive.
// Assumes AXI4-Lite master on aclk; inputs and keys are levels sampled on aclk.
`timescale 1ns/1ps
`default_nettype none
`include "servo_map.vh"
module servo_speed_select_and_jog (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [6:0]  s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [6:0]  s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire [8:0]  din,
  input  wire [15:0] analog_ref,
  input  wire        key_mode,
  input  wire        key_set,
  input  wire        key_up,
  input  wire        key_down,
  input  wire        key_shift,
  output reg  [31:0] speed_cmd,
  output reg         speed_cmd_analog,
  output reg         servo_active,
  output reg         torque_limit_enable,
  output reg         jog_active,
  output reg         motor_run_ccw,
  output reg         motor_run_cw,
  output reg         emergency_stop_fault,
  output reg         reverse_limit_fault,
  output reg         forward_limit_fault,
  output reg  [7:0]  control_mode_active
);
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_EDIT = 3'b010;
  localparam [2:0] ST_JOG  = 3'b100;

  reg        aw_hold_q;
  reg        w_hold_q;
  reg [6:0]  awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0]  wstrb_q;
  reg        sw_servo_on_q;
  reg        restart_q;
  reg [7:0]  control_mode_param_q;
  reg [31:0] speed_preset_one_q;
  reg [31:0] speed_preset_two_q;
  reg [31:0] speed_preset_three_q;
  reg [15:0] jog_speed_param_q;
  reg [11:0] func_code_q [0:8];
  reg [8:0]  din_meta_q;
  reg [8:0]  din_sync_q;
  reg        alarm_clear_input_prev_q;
  reg [4:0]  key_prev_q;
  reg [2:0]  state_q;
  reg [15:0] edit_q;
  reg [1:0]  digit_q;
  reg [31:0] rd_data;
  reg        rd_ok;
  reg        wr_ok;
  reg [7:0]  on_all;
  reg [7:0]  off_all;
  reg [15:0] step;
  reg [31:0] speed_d;
  reg [31:0] jog_mag;
  reg [31:0] wmerge;
  reg [31:0] fmerge;
  reg [3:0]  fidx_w;
  reg [3:0]  fidx_r;
  wire [71:0] on_flat;
  wire [71:0] off_flat;
  wire [6:0]  fofs_w  = awaddr_q - `OFS_FUNC_BASE;
  wire [6:0]  fofs_r  = s_axi_araddr - `OFS_FUNC_BASE;
  wire        aw_take = s_axi_awvalid & s_axi_awready;
  wire        w_take  = s_axi_wvalid & s_axi_wready;
  wire        wr_do   = aw_hold_q & w_hold_q & ~s_axi_bvalid;
  wire        ar_take = s_axi_arvalid & s_axi_arready;
  wire [4:0]  keys    = {key_shift, key_down, key_up, key_set, key_mode};
  wire [4:0]  key_hit = keys & ~key_prev_q;
  wire        alarm_clear_input_rise = on_all[`F_ALARM_CLEAR_INPUT] & ~alarm_clear_input_prev_q;
  wire        fault_clr = alarm_clear_input_rise | restart_q;
  wire        speed_mode = (control_mode_active == `MODE_SPEED);
  integer     i;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  strb;
    integer b;
    begin
      merge = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (strb[b]) merge[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
  endfunction

  function [31:0] clamp_preset;
    input [31:0] v;
    begin
      if ($signed(v) > $signed(`PRESET_MAX)) clamp_preset = `PRESET_MAX;
      else if ($signed(v) < $signed(`PRESET_MIN)) clamp_preset = `PRESET_MIN;
      else clamp_preset = v;
    end
  endfunction

  function func_range;
    input [6:0] a;
    begin
      func_range = (a >= `OFS_FUNC_BASE) && (a <= `OFS_FUNC_LAST) && (a[1:0] == 2'h0);
    end
  endfunction

  genvar g;
  generate
    for (g = 0; g < 9; g = g + 1) begin : gen_dec
      input_function_decode u_dec (
        .code    (func_code_q[g]),
        .level   (din_sync_q[g]),
        .on_vec  (on_flat[g*8 +: 8]),
        .off_vec (off_flat[g*8 +: 8])
      );
    end
  endgenerate

  always @* begin
    on_all  = 8'h00;
    off_all = 8'h00;
    for (i = 0; i < 9; i = i + 1) begin
      on_all  = on_all | on_flat[i*8 +: 8];
      off_all = off_all | off_flat[i*8 +: 8];
    end
  end

  // Function-register index; only meaningful when the address is in range
  always @* begin
    fidx_w = 4'h0;
    fidx_r = 4'h0;
    if (func_range(awaddr_q)) fidx_w = fofs_w[5:2];
    if (func_range(s_axi_araddr)) fidx_r = fofs_r[5:2];
    wmerge = merge(32'h00000000, wdata_q, wstrb_q);
    fmerge = merge({20'h00000, func_code_q[fidx_w]}, wdata_q, wstrb_q);
  end

  always @* begin
    wr_ok = 1'b1;
    case (awaddr_q)
      `OFS_CTRL, `OFS_MODE, `OFS_PRESET1, `OFS_PRESET2, `OFS_PRESET3, `OFS_JOG: wr_ok = 1'b1;
      default: wr_ok = func_range(awaddr_q);
    endcase
  end

  always @* begin
    rd_data = 32'h00000000;
    rd_ok   = 1'b1;
    case (s_axi_araddr)
      `OFS_CTRL: rd_data[`CTRL_SON_BIT] = sw_servo_on_q;
      `OFS_MODE: begin
        rd_data[7:0] = control_mode_param_q;
        rd_data[`MODE_ACTIVE_LSB +: 8] = control_mode_active;
      end
      `OFS_PRESET1: rd_data = speed_preset_one_q;
      `OFS_PRESET2: rd_data = speed_preset_two_q;
      `OFS_PRESET3: rd_data = speed_preset_three_q;
      `OFS_JOG:     rd_data[15:0] = jog_speed_param_q;
      `OFS_STATUS: begin
        rd_data[`ST_FLT_EMG] = emergency_stop_fault;
        rd_data[`ST_FLT_NL]  = reverse_limit_fault;
        rd_data[`ST_FLT_PL]  = forward_limit_fault;
        rd_data[`ST_SERVO]   = servo_active;
        rd_data[`ST_JOG]     = jog_active;
        rd_data[`ST_SPEED_SELECT_LOW]    = on_all[`F_SPEED_SELECT_LOW];
        rd_data[`ST_SPEED_SELECT_HIGH]    = on_all[`F_SPEED_SELECT_HIGH];
        rd_data[`ST_TRQ]     = torque_limit_enable;
        rd_data[`ST_ANALOG]  = speed_cmd_analog;
      end
      `OFS_SPEED: rd_data = speed_cmd;
      default: begin
        rd_ok = func_range(s_axi_araddr);
        if (rd_ok) rd_data[11:0] = func_code_q[fidx_r];
      end
    endcase
  end

  // AXI4-Lite slave: address and data taken in either order, one write and one read
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= `RESP_OKAY;
      s_axi_rdata   <= 32'h00000000;
      aw_hold_q     <= 1'b0;
      w_hold_q      <= 1'b0;
      awaddr_q      <= 7'h00;
      wdata_q       <= 32'h00000000;
      wstrb_q       <= 4'h0;
    end else begin
      if (aw_take) begin
        awaddr_q      <= s_axi_awaddr;
        aw_hold_q     <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (w_take) begin
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
        w_hold_q     <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_do) begin
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
      if (ar_take) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_data;
        s_axi_rresp   <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Register file; the keypad confirm also writes the jog speed, bus write takes precedence
  always @(posedge aclk) begin
    if (!aresetn) begin
      sw_servo_on_q        <= 1'b0;
      restart_q            <= 1'b0;
      control_mode_param_q <= `MODE_RST;
      control_mode_active  <= `MODE_RST;
      speed_preset_one_q   <= 32'h00000000;
      speed_preset_two_q   <= 32'h00000000;
      speed_preset_three_q <= 32'h00000000;
      jog_speed_param_q    <= `JOG_RST;
      func_code_q[0] <= `FN_SON;
      func_code_q[1] <= `FN_TRQ;
      func_code_q[2] <= `FN_SPEED_SELECT_LOW;
      func_code_q[3] <= `FN_SPEED_SELECT_HIGH;
      func_code_q[4] <= `FN_ALARM_CLEAR_INPUT;
      func_code_q[5] <= `FN_NL;
      func_code_q[6] <= `FN_PL;
      func_code_q[7] <= `FN_EMG;
      func_code_q[8] <= `FN_NONE;
    end else begin
      restart_q <= 1'b0;
      if (restart_q) control_mode_active <= control_mode_param_q;
      if (state_q == ST_EDIT && key_hit[1]) jog_speed_param_q <= edit_q;
      if (wr_do) begin
        case (awaddr_q)
          `OFS_CTRL: if (wstrb_q[0]) begin
            sw_servo_on_q <= wdata_q[`CTRL_SON_BIT];
            restart_q     <= wdata_q[`CTRL_RESTART_BIT];
          end
          `OFS_MODE: if (wstrb_q[0]) control_mode_param_q <= wdata_q[7:0];
          `OFS_PRESET1: speed_preset_one_q <=
            clamp_preset(merge(speed_preset_one_q, wdata_q, wstrb_q));
          `OFS_PRESET2: speed_preset_two_q <=
            clamp_preset(merge(speed_preset_two_q, wdata_q, wstrb_q));
          `OFS_PRESET3: speed_preset_three_q <=
            clamp_preset(merge(speed_preset_three_q, wdata_q, wstrb_q));
          `OFS_JOG: jog_speed_param_q <=
            merge({16'h0000, jog_speed_param_q}, wdata_q, wstrb_q) > {16'h0000, `JOG_MAX} ?
            `JOG_MAX : wmerge[15:0] | (jog_speed_param_q & ~{{8{wstrb_q[1]}}, {8{wstrb_q[0]}}});
          default: if (func_range(awaddr_q)) begin
            func_code_q[fidx_w] <= fmerge[11:0];
          end
        endcase
      end
    end
  end

  // Inputs, faults and servo state
  always @(posedge aclk) begin
    if (!aresetn) begin
      din_meta_q           <= 9'h000;
      din_sync_q           <= 9'h000;
      alarm_clear_input_prev_q          <= 1'b0;
      emergency_stop_fault <= 1'b0;
      reverse_limit_fault  <= 1'b0;
      forward_limit_fault  <= 1'b0;
      servo_active         <= 1'b0;
      torque_limit_enable  <= 1'b0;
    end else begin
      din_meta_q  <= din;
      din_sync_q  <= din_meta_q;
      alarm_clear_input_prev_q <= on_all[`F_ALARM_CLEAR_INPUT];
      // A fault still present at the clear sets again; set wins over clear
      emergency_stop_fault <= off_all[`F_EMG] | (emergency_stop_fault & ~fault_clr);
      reverse_limit_fault  <= off_all[`F_NL] | (reverse_limit_fault & ~fault_clr);
      forward_limit_fault  <= off_all[`F_PL] | (forward_limit_fault & ~fault_clr);
      servo_active <= (sw_servo_on_q | on_all[`F_SON]) &
                      ~(emergency_stop_fault | reverse_limit_fault | forward_limit_fault);
      torque_limit_enable <= on_all[`F_TRQ];
    end
  end

  // Keypad jog: edit, confirm, run while a key is held
  always @* begin
    case (digit_q)
      2'h0:    step = `STEP0;
      2'h1:    step = `STEP1;
      2'h2:    step = `STEP2;
      default: step = `STEP3;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      state_q    <= ST_IDLE;
      key_prev_q <= 5'h00;
      edit_q     <= `JOG_RST;
      digit_q    <= 2'h0;
    end else begin
      key_prev_q <= keys;
      case (state_q)
        ST_IDLE: if (key_hit[1]) begin
          state_q <= ST_EDIT;
          edit_q  <= jog_speed_param_q;
          digit_q <= 2'h0;
        end
        ST_EDIT: begin
          if (key_hit[0]) state_q <= ST_IDLE;
          else if (key_hit[1]) state_q <= servo_active ? ST_JOG : ST_IDLE;
          else if (key_hit[2]) edit_q <= (edit_q > `JOG_MAX - step) ? `JOG_MAX : edit_q + step;
          else if (key_hit[3]) edit_q <= (edit_q < step) ? 16'h0000 : edit_q - step;
          else if (key_hit[4]) digit_q <= (digit_q == `DIGIT_LAST) ? 2'h0 : digit_q + 2'h1;
        end
        ST_JOG: if (key_hit[0] || !servo_active) state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Speed command: jog overrides the preset selection
  always @* begin
    jog_mag = {16'h0000, jog_speed_param_q} * `JOG_SCALE;
    speed_d = 32'h00000000;
    if (servo_active && state_q == ST_JOG) begin
      if (key_up && !key_down) speed_d = 32'h00000000 - jog_mag;
      else if (key_down && !key_up) speed_d = jog_mag;
    end else if (servo_active && speed_mode) begin
      // No check that the motor is fixed; that stays with the operator
      case ({on_all[`F_SPEED_SELECT_HIGH], on_all[`F_SPEED_SELECT_LOW]})
        2'b00:   speed_d = {{16{analog_ref[15]}}, analog_ref};
        2'b01:   speed_d = speed_preset_one_q;
        2'b10:   speed_d = speed_preset_two_q;
        default: speed_d = speed_preset_three_q;
      endcase
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      speed_cmd        <= 32'h00000000;
      speed_cmd_analog <= 1'b0;
      jog_active       <= 1'b0;
      motor_run_ccw    <= 1'b0;
      motor_run_cw     <= 1'b0;
    end else begin
      speed_cmd        <= speed_d;
      speed_cmd_analog <= servo_active && speed_mode && state_q != ST_JOG &&
                          !on_all[`F_SPEED_SELECT_LOW] && !on_all[`F_SPEED_SELECT_HIGH];
      jog_active       <= (state_q == ST_JOG);
      motor_run_ccw    <= servo_active && state_q == ST_JOG && key_up && !key_down;
      motor_run_cw     <= servo_active && state_q == ST_JOG && key_down && !key_up;
    end
  end
endmodule
`default_nettype wire

//--- testbench/far_side_model.sv
// Keypad and external controller facing the servo command block.
// Assumes the bench calls its tasks right after a rising edge of aclk.
`timescale 1ns/1ps
`default_nettype none
module far_side_model (
  input  wire logic       aclk,
  output var  logic [8:0] din,
  output var  logic [4:0] keys
);
  initial begin
    din = 9'h000;
    keys = 5'h00;
  end

  // Whole input word at once so selects change in the same cycle
  task automatic drive(input logic [8:0] v);
    @(posedge aclk);
    din <= v;
  endtask

  task hold_key(input int i, input logic v);
    @(posedge aclk);
    keys[i] <= v;
  endtask

  // Long enough high and low that the edge-detected key, sampled on aclk without a synchroniser, still shows one press
  task automatic press(input int i);
    hold_key(i, 1'b1);
    repeat (2) @(posedge aclk);
    hold_key(i, 1'b0);
    repeat (3) @(posedge aclk);
  endtask
endmodule
`default_nettype wire

//--- testbench/servo_cmd_monitor.sv
// Port-level checker for the servo command block, bound into its top module.
// Assumes one clock, aclk, and a synchronous active-low reset, aresetn.
`timescale 1ns/1ps
`default_nettype none
`include "servo_map.vh"
module servo_cmd_monitor (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [15:0] analog_ref,
  input wire logic [31:0] speed_cmd,
  input wire logic        speed_cmd_analog,
  input wire logic        servo_active,
  input wire logic        jog_active,
  input wire logic        motor_run_ccw,
  input wire logic        motor_run_cw,
  input wire logic        emergency_stop_fault,
  input wire logic        reverse_limit_fault,
  input wire logic        forward_limit_fault
);
  wire any_fault = emergency_stop_fault | reverse_limit_fault | forward_limit_fault;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_write_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write channel open while response pending");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready) else $error("read answer late");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data changed while pending");
  // Sign only: the magnitude depends on the edited jog speed
  a_ccw_sign: assert property (motor_run_ccw |-> jog_active && !motor_run_cw &&
    (speed_cmd[31] || speed_cmd == 32'h0)) else $error("counterclockwise run wrong");
  a_cw_sign: assert property (motor_run_cw |-> jog_active && !speed_cmd[31])
    else $error("clockwise run wrong");
  a_analog_pass: assert property (speed_cmd_analog && !jog_active &&
    $stable(analog_ref) |-> speed_cmd == {{16{analog_ref[15]}}, analog_ref})
    else $error("analog reference not passed on");
  a_fault_drops: assert property (any_fault && $past(any_fault) |-> !servo_active)
    else $error("drive energised during fault");
  a_jog_servo: assert property ($rose(jog_active) |-> servo_active)
    else $error("jog entered without drive energised");

  c_ccw: cover property (motor_run_ccw);
  c_cw: cover property (motor_run_cw);
  c_analog: cover property (speed_cmd_analog);
  c_slverr: cover property (s_axi_rvalid && s_axi_rresp == `RESP_SLVERR);
endmodule

bind servo_speed_select_and_jog servo_cmd_monitor u_mon (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .analog_ref(analog_ref), .speed_cmd(speed_cmd), .speed_cmd_analog(speed_cmd_analog),
  .servo_active(servo_active), .jog_active(jog_active), .motor_run_ccw(motor_run_ccw),
  .motor_run_cw(motor_run_cw), .emergency_stop_fault(emergency_stop_fault),
  .reverse_limit_fault(reverse_limit_fault), .forward_limit_fault(forward_limit_fault)
);
`default_nettype wire

//--- testbench/testbench.sv
// Self-checking bench: register bus, digital inputs and keypad of the command block.
// Assumes the far side model drives din and the keys.
`timescale 1ns/1ps
`default_nettype none
`include "servo_map.vh"
module testbench;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_rready;
  logic [6:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, v, ex[4];
  logic [15:0] analog_ref;
  logic [1:0] r;
  logic [3:0] s_axi_wstrb;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata, speed_cmd;
  wire logic speed_cmd_analog, servo_active, torque_limit_enable, jog_active;
  wire logic motor_run_ccw, motor_run_cw, emergency_stop_fault;
  wire logic reverse_limit_fault, forward_limit_fault;
  wire logic [7:0] control_mode_active;
  wire logic [8:0] din;
  wire logic [4:0] keys;
  int checked = 0;
  int miscompares = 0;

  servo_speed_select_and_jog DUT (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .din(din),
    .analog_ref(analog_ref), .key_mode(keys[0]), .key_set(keys[1]), .key_up(keys[2]),
    .key_down(keys[3]), .key_shift(keys[4]), .speed_cmd(speed_cmd),
    .speed_cmd_analog(speed_cmd_analog), .servo_active(servo_active),
    .torque_limit_enable(torque_limit_enable), .jog_active(jog_active),
    .motor_run_ccw(motor_run_ccw), .motor_run_cw(motor_run_cw),
    .emergency_stop_fault(emergency_stop_fault), .reverse_limit_fault(reverse_limit_fault),
    .forward_limit_fault(forward_limit_fault), .control_mode_active(control_mode_active)
  );
  far_side_model u_far (.aclk(aclk), .din(din), .keys(keys));

  always #20 aclk = ~aclk;

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [32:0] got, input logic [32:0] exp);
    checked++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", nm, exp, got);
      miscompares++;
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    int n;
    logic ta, tw, done;
    done = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50 && !done; n++) begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      done = s_axi_bvalid;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (done) s_axi_bready <= 1'b0;
    end
    if (!done) begin
      miscompares++;
      tally_and_finish();
    end
    @(posedge aclk);
  endtask

  task automatic rd(input logic [6:0] a, output logic [31:0] d, output logic [1:0] rr);
    int n;
    logic ta, done;
    done = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50 && !done; n++) begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      done = s_axi_rvalid;
      d = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (done) s_axi_rready <= 1'b0;
    end
    if (!done) begin
      miscompares++;
      tally_and_finish();
    end
    @(posedge aclk);
  endtask

  // Covers the 2-flop input sync plus the select and output stages
  task automatic settle;
    repeat (8) @(posedge aclk);
  endtask

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 7'h00;
    s_axi_araddr = 7'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    analog_ref = 16'h8123;
    ex = '{32'hFFFF8123, 32'h0000C350, 32'hFFFF3CB0, 32'hFFFF8AD0};
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    settle();
    chk("mode_rst", control_mode_active, 32'h0);
    chk("faults", {emergency_stop_fault, reverse_limit_fault, forward_limit_fault}, 3'h7);
    rd(`OFS_JOG, v, r);
    chk("jog_rst", v, 32'h14);
    u_far.drive(9'h0E0);
    wr(`OFS_MODE, 32'h2);
    settle();
    chk("mode_pend", control_mode_active, 32'h0);
    wr(`OFS_CTRL, 32'h2);
    settle();
    chk("mode_new", control_mode_active, 32'h2);
    chk("restart_clr", {emergency_stop_fault, reverse_limit_fault}, 2'h0);
    wr(`OFS_PRESET1, 32'h0000C351);
    wr(`OFS_PRESET2, 32'hFFFF3CAF);
    wr(`OFS_PRESET3, 32'hFFFF8AD0);
    rd(`OFS_PRESET1, v, r);
    chk("clamp_hi", v, 32'h0000C350);
    rd(`OFS_PRESET2, v, r);
    chk("clamp_lo", v, 32'hFFFF3CB0);
    u_far.drive(9'h0E1);
    settle();
    chk("servo_in", servo_active, 32'h1);
    for (int s = 0; s < 4; s++) begin
      u_far.drive(9'h0E1 | (s << 2));
      settle();
      chk("speed", speed_cmd, ex[s]);
      chk("analog", speed_cmd_analog, s == 0);
    end
    s_axi_wstrb <= 4'h1;
    wr(`OFS_PRESET1, 32'h0);
    s_axi_wstrb <= 4'hF;
    rd(`OFS_PRESET1, v, r);
    chk("strobe", v, 32'h0000C300);
    wr(`OFS_FUNC_BASE + 7'h08, 32'h0);
    u_far.drive(9'h0E7);
    settle();
    chk("disabled_in", speed_cmd, ex[0]);
    chk("torque", torque_limit_enable, 32'h1);
    wr(`OFS_FUNC_LAST, 32'h022);
    settle();
    chk("rev_fault", {reverse_limit_fault, servo_active}, 2'h2);
    u_far.drive(9'h1E1);
    settle();
    u_far.drive(9'h1F1);
    settle();
    chk("alarm_clr", reverse_limit_fault, 32'h0);
    wr(`OFS_FUNC_LAST, 32'h021);
    u_far.drive(9'h0F1);
    settle();
    chk("emg_fault", emergency_stop_fault, 32'h1);
    u_far.drive(9'h1E1);
    settle();
    u_far.drive(9'h1F1);
    settle();
    chk("emg_clr", emergency_stop_fault, 32'h0);
    rd(7'h7C, v, r);
    chk("unmapped", r, `RESP_SLVERR);
    analog_ref <= 16'h0000;
    u_far.drive(9'h1F0);
    settle();
    chk("servo_off", servo_active, 32'h0);
    wr(`OFS_CTRL, 32'h1);
    settle();
    chk("soft_servo", servo_active, 32'h1);
    u_far.press(1);
    u_far.press(2);
    u_far.press(4);
    u_far.press(2);
    u_far.press(3);
    u_far.press(1);
    settle();
    chk("jog_on", jog_active, 32'h1);
    rd(`OFS_JOG, v, r);
    chk("jog_edit", v, 32'd21);
    u_far.hold_key(2, 1'b1);
    settle();
    chk("ccw", {motor_run_ccw, motor_run_cw}, 2'h2);
    chk("ccw_speed", speed_cmd, 32'hFFFFFF2E);
    u_far.hold_key(2, 1'b0);
    settle();
    chk("ccw_stop", {motor_run_ccw, speed_cmd}, 33'h0);
    u_far.hold_key(3, 1'b1);
    settle();
    chk("cw", {motor_run_ccw, motor_run_cw}, 2'h1);
    chk("cw_speed", speed_cmd, 32'h000000D2);
    u_far.hold_key(3, 1'b0);
    settle();
    chk("cw_stop", {motor_run_cw, speed_cmd}, 33'h0);
    u_far.press(0);
    settle();
    chk("jog_off", jog_active, 32'h0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
